// ### include/ufc_defines.vh
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH
`define UFC_ADDR_DATA    3'h0
`define UFC_ADDR_DIVLO   3'h1
`define UFC_ADDR_DIVHI   3'h2
`define UFC_ADDR_FCR     3'h3
`define UFC_ADDR_TLR     3'h4
`define UFC_ADDR_MCR     3'h5
`define UFC_ADDR_STAT    3'h6
`define UFC_ADDR_EFR_TCR 3'h7
`define UFC_FCR_EN       0
`define UFC_FCR_TXT_LO   4
`define UFC_FCR_RXT_LO   6
`define UFC_MCR_RTS      1
`define UFC_MCR_LOOP     4
`define UFC_EFR_ARTS     6
`define UFC_EFR_ACTS     7
`define UFC_DIV_RESET    16'h0001
`define UFC_OVERSAMPLE   16
`define UFC_ERR_OVERRUN  0
`endif

// ### rtl/ufc_fifo.v
`timescale 1ns/1ns
module ufc_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    input  wire             mclk,
    input  wire             rst_n,
    input  wire             flush,
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    input  wire             rd_en,
    output reg  [WIDTH-1:0] rd_data,
    output reg  [AW:0]      count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_reg;
    reg [AW-1:0]    rp_reg;
    wire            do_wr = wr_en && (count != DEPTH[AW:0]);
    wire            do_rd = rd_en && (count != {(AW+1){1'b0}});
    always @(posedge mclk) begin
        if (do_wr)
            mem[wp_reg] <= wr_data;
        rd_data <= mem[rp_reg];
    end
    always @(posedge mclk) begin
        if (!rst_n || flush) begin
            wp_reg <= {AW{1'b0}};
            rp_reg <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr)
                wp_reg <= wp_reg + 1'b1;
            if (do_rd)
                rp_reg <= rp_reg + 1'b1;
            if (do_wr && !do_rd)
                count <= count + 1'b1;
            else if (do_rd && !do_wr)
                count <= count - 1'b1;
        end
    end
endmodule // ufc_fifo

// ### rtl/ufc_serial.v
`timescale 1ns/1ns
`include "ufc_defines.vh"
// one serial engine: baud tick, transmitter and receiver, 8N1
module ufc_serial (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [15:0] divisor,
    input  wire        tx_start,
    input  wire [7:0]  tx_byte,
    output reg         tx_busy,
    output reg         tx_line,
    output reg         tx_last_mid,
    input  wire        rx_line,
    output reg         rx_done,
    output reg  [7:0]  rx_byte,
    output reg         rx_frame_err
);
    reg [15:0] div_cnt_reg;
    reg        tick;
    reg [3:0]  tx_ph_reg;
    reg [3:0]  tx_bit_reg;
    reg [8:0]  tx_sh_reg;
    reg [3:0]  rx_ph_reg;
    reg [3:0]  rx_bit_reg;
    reg        rx_act_reg;
    reg [7:0]  rx_sh_reg;
    // a divisor of zero is treated as one
    always @(posedge mclk) begin
        if (!rst_n) begin
            div_cnt_reg <= 16'h0000;
            tick        <= 1'b0;
        end else if (div_cnt_reg + 16'h0001 >= divisor) begin
            div_cnt_reg <= 16'h0000;
            tick        <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
            tick        <= 1'b0;
        end
    end
    always @(posedge mclk) begin
        if (!rst_n) begin
            tx_busy     <= 1'b0;
            tx_line     <= 1'b1;
            tx_ph_reg   <= 4'h0;
            tx_bit_reg  <= 4'h0;
            tx_sh_reg   <= 9'h1FF;
            tx_last_mid <= 1'b0;
        end else if (!tx_busy) begin
            tx_last_mid <= 1'b0;
            if (tx_start) begin
                tx_busy    <= 1'b1;
                tx_line    <= 1'b0;
                tx_sh_reg  <= {1'b1, tx_byte};
                tx_ph_reg  <= 4'h0;
                tx_bit_reg <= 4'h0;
            end
        end else if (tick) begin
            tx_ph_reg <= tx_ph_reg + 4'h1;
            // stop bit midpoint: cts is judged from here until the frame ends
            if (tx_bit_reg == 4'h9 && tx_ph_reg == 4'h7)
                tx_last_mid <= 1'b1;
            if (tx_ph_reg == 4'hF) begin
                if (tx_bit_reg == 4'h9) begin
                    tx_busy <= 1'b0;
                    tx_line <= 1'b1;
                end else begin
                    tx_line    <= tx_sh_reg[0];
                    tx_sh_reg  <= {1'b1, tx_sh_reg[8:1]};
                    tx_bit_reg <= tx_bit_reg + 4'h1;
                end
            end
        end
    end
    always @(posedge mclk) begin
        if (!rst_n) begin
            rx_act_reg   <= 1'b0;
            rx_ph_reg    <= 4'h0;
            rx_bit_reg   <= 4'h0;
            rx_sh_reg    <= 8'h00;
            rx_done      <= 1'b0;
            rx_byte      <= 8'h00;
            rx_frame_err <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!rx_act_reg) begin
                if (!rx_line) begin
                    rx_act_reg <= 1'b1;
                    rx_ph_reg  <= 4'h0;
                    rx_bit_reg <= 4'h0;
                end
            end else if (tick) begin
                rx_ph_reg <= rx_ph_reg + 4'h1;
                if (rx_ph_reg == 4'h7) begin
                    rx_bit_reg <= rx_bit_reg + 4'h1;
                    if (rx_bit_reg == 4'h0 && rx_line)
                        rx_act_reg <= 1'b0;
                    else if (rx_bit_reg == 4'h9) begin
                        rx_act_reg   <= 1'b0;
                        rx_done      <= 1'b1;
                        rx_byte      <= rx_sh_reg;
                        rx_frame_err <= !rx_line;
                    end else if (rx_bit_reg != 4'h0)
                        rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
                end
            end
        end
    end
endmodule // ufc_serial

// ### rtl/ufc_top.v
`timescale 1ns/1ns
`include "ufc_defines.vh"
module ufc_top #(
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       cs_n,
    input  wire       channel_addr_bit,
    input  wire [2:0] addr,
    input  wire [7:0] wr_data,
    input  wire       wr_stb,
    input  wire       rd_stb,
    output reg  [7:0] rd_data,
    input  wire       serial_in_chan0,
    input  wire       serial_in_chan1,
    input  wire       cts_n_chan0,
    input  wire       cts_n_chan1,
    output reg        serial_out_chan0,
    output reg        serial_out_chan1,
    output reg        rts_n_chan0,
    output reg        rts_n_chan1,
    output reg        rx_ready_n_chan0,
    output reg        rx_ready_n_chan1,
    output reg        tx_ready_n_chan0,
    output reg        tx_ready_n_chan1,
    output reg        cts_change_chan0,
    output reg        cts_change_chan1
);
    // fixed trigger tables
    function [6:0] fixed_rx;
        input [1:0] sel;
        case (sel)
            2'h0:    fixed_rx = 7'd8;
            2'h1:    fixed_rx = 7'd16;
            2'h2:    fixed_rx = 7'd56;
            default: fixed_rx = 7'd60;
        endcase
    endfunction
    function [6:0] fixed_tx;
        input [1:0] sel;
        case (sel)
            2'h0:    fixed_tx = 7'd8;
            2'h1:    fixed_tx = 7'd16;
            2'h2:    fixed_tx = 7'd32;
            default: fixed_tx = 7'd56;
        endcase
    endfunction
    // nibble in steps of four, zero nibble falls back to fixed table
    function [6:0] level4;
        input [3:0] nib;
        input [6:0] alt;
        level4 = (nib == 4'h0) ? alt : {1'b0, nib, 2'b00};
    endfunction

    localparam ST_IDLE = 3'b001;
    localparam ST_LOAD = 3'b010;
    localparam ST_SEND = 3'b100;

    reg  [1:0]  sel;
    wire [15:0] rd_mux;
    wire [1:0]  serial_in_pin = {serial_in_chan1, serial_in_chan0};
    wire [1:0]  cts_n_pin     = {cts_n_chan1, cts_n_chan0};
    wire [1:0]  ser_tx_line;
    wire [1:0]  rx_ready_n_next;
    wire [1:0]  tx_ready_n_next;
    wire [1:0]  rts_n_next;
    wire [1:0]  serial_out_next;
    wire [1:0]  cts_change_next;

    // channel decode
    always @* begin
        sel[0] = !cs_n && !channel_addr_bit;
        sel[1] = !cs_n &&  channel_addr_bit;
    end

    // each channel is a full independent copy
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            reg  [7:0]    fcr_reg;
            reg  [7:0]    tlr_reg;
            reg  [7:0]    mcr_reg;
            reg  [7:0]    efr_reg;
            reg  [7:0]    tcr_reg;
            reg  [15:0]   div_reg;
            reg  [2:0]    tx_st_reg;
            reg           rts_halt_reg;
            reg           overrun_reg;
            reg           cts_q_reg;
            reg           cts_chg_reg;
            reg           tx_start_reg;
            reg  [7:0]    rd_val;
            wire          wr_sel  = wr_stb && sel[ch];
            wire          rd_sel  = rd_stb && sel[ch];
            wire          fifo_on = fcr_reg[`UFC_FCR_EN];
            wire          loop_on = mcr_reg[`UFC_MCR_LOOP];
            wire [AW:0]   depth_eff = fifo_on ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1};
            wire [AW:0]   tx_cnt;
            wire [AW:0]   rx_cnt;
            wire [7:0]    tx_q;
            wire [10:0]   rx_q;
            wire          s_busy;
            wire          s_mid;
            wire          s_done;
            wire [7:0]    s_byte;
            wire          s_ferr;
            // loop-back ties tx into rx, pin ignored
            wire          rx_src  = loop_on ? ser_tx_line[ch] : serial_in_pin[ch];
            wire [6:0]    rx_trig = fifo_on ? level4(tlr_reg[7:4],
                                      fixed_rx(fcr_reg[7:6])) : 7'd1;
            wire [6:0]    tx_trig = fifo_on ? level4(tlr_reg[3:0],
                                      fixed_tx(fcr_reg[5:4])) : 7'd1;
            wire [6:0]    halt_lv   = {1'b0, tcr_reg[3:0], 2'b00};
            wire [6:0]    resume_lv = {1'b0, tcr_reg[7:4], 2'b00};
            wire          rx_full = (rx_cnt == depth_eff);
            wire          tx_full = (tx_cnt == depth_eff);
            wire          auto_cts = efr_reg[`UFC_EFR_ACTS];
            wire          auto_rts = efr_reg[`UFC_EFR_ARTS];
            // cts level followed from stop-bit midpoint to end of frame, and while idle
            reg           cts_ok_reg;
            wire          tx_pop = (tx_st_reg == ST_IDLE) && (tx_cnt != 0) &&
                                   (!auto_cts || cts_ok_reg);

            // fifos hold 64 entries; rx carries 3 error bits
            ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_txf (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .flush   (wr_sel && addr == `UFC_ADDR_FCR && wr_data[2]),
                .wr_en   (wr_sel && addr == `UFC_ADDR_DATA && !tx_full),
                .wr_data (wr_data),
                .rd_en   (tx_pop),
                .rd_data (tx_q),
                .count   (tx_cnt)
            );
            ufc_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_rxf (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .flush   (wr_sel && addr == `UFC_ADDR_FCR && wr_data[1]),
                // extra char after rts drop is still stored
                .wr_en   (s_done && !rx_full),
                .wr_data ({1'b0, s_ferr, 1'b0, s_byte}),
                .rd_en   (rd_sel && addr == `UFC_ADDR_DATA),
                .rd_data (rx_q),
                .count   (rx_cnt)
            );
            ufc_serial u_ser (
                .mclk         (mclk),
                .rst_n        (rst_n),
                .divisor      (div_reg),
                .tx_start     (tx_start_reg),
                .tx_byte      (tx_q),
                .tx_busy      (s_busy),
                .tx_line      (ser_tx_line[ch]),
                .tx_last_mid  (s_mid),
                .rx_line      (rx_src),
                .rx_done      (s_done),
                .rx_byte      (s_byte),
                .rx_frame_err (s_ferr)
            );

            always @(posedge mclk) begin
                if (!rst_n) begin
                    fcr_reg <= 8'h00;
                    tlr_reg <= 8'h00;
                    mcr_reg <= 8'h00;
                    efr_reg <= 8'h00;
                    tcr_reg <= 8'h00;
                    div_reg <= `UFC_DIV_RESET;
                end else if (wr_sel) begin
                    case (addr)
                        `UFC_ADDR_DIVLO:   div_reg[7:0]  <= wr_data;
                        `UFC_ADDR_DIVHI:   div_reg[15:8] <= wr_data;
                        `UFC_ADDR_FCR:     fcr_reg <= wr_data;
                        `UFC_ADDR_TLR:     tlr_reg <= wr_data;
                        `UFC_ADDR_MCR:     mcr_reg <= wr_data;
                        `UFC_ADDR_EFR_TCR: begin
                            if (mcr_reg[7])
                                tcr_reg <= wr_data;
                            else
                                efr_reg <= wr_data;
                        end
                        default: ;
                    endcase
                end
            end

            always @(posedge mclk) begin
                if (!rst_n) begin
                    tx_st_reg    <= ST_IDLE;
                    tx_start_reg <= 1'b0;
                    cts_ok_reg   <= 1'b0;
                end else begin
                    tx_start_reg <= 1'b0;
                    if (s_mid || tx_st_reg == ST_IDLE)
                        cts_ok_reg <= !cts_n_pin[ch];
                    case (tx_st_reg)
                        // start with the pop: the fifo output moves on one edge later
                        ST_IDLE: if (tx_pop) begin
                            tx_start_reg <= 1'b1;
                            tx_st_reg    <= ST_LOAD;
                        end
                        ST_LOAD: tx_st_reg <= ST_SEND;
                        ST_SEND: if (!s_busy && !tx_start_reg) tx_st_reg <= ST_IDLE;
                        default: tx_st_reg <= ST_IDLE;
                    endcase
                end
            end

            // sticky overrun: a new overrun wins over the read clear
            always @(posedge mclk) begin
                if (!rst_n) begin
                    overrun_reg  <= 1'b0;
                    rts_halt_reg <= 1'b0;
                    cts_q_reg    <= 1'b1;
                    cts_chg_reg  <= 1'b0;
                end else begin
                    if (s_done && rx_full)
                        overrun_reg <= 1'b1;
                    else if (rd_sel && addr == `UFC_ADDR_STAT)
                        overrun_reg <= 1'b0;
                    if (rx_cnt >= halt_lv)
                        rts_halt_reg <= 1'b1;
                    else if (rx_cnt <= resume_lv)
                        rts_halt_reg <= 1'b0;
                    cts_q_reg   <= cts_n_pin[ch];
                    cts_chg_reg <= !auto_cts && (cts_q_reg != cts_n_pin[ch]);
                end
            end

            // read value is combinational so the top flop answers one cycle after the strobe
            always @* begin
                case (addr)
                    `UFC_ADDR_DATA:   rd_val = rx_q[7:0];
                    `UFC_ADDR_DIVLO:  rd_val = div_reg[7:0];
                    `UFC_ADDR_DIVHI:  rd_val = div_reg[15:8];
                    `UFC_ADDR_FCR:    rd_val = fcr_reg;
                    `UFC_ADDR_TLR:    rd_val = tlr_reg;
                    `UFC_ADDR_MCR:    rd_val = mcr_reg;
                    `UFC_ADDR_STAT:   rd_val = {tx_cnt == 0, tx_full, rx_full,
                                                overrun_reg, rx_q[10:8],
                                                rx_cnt != 0};
                    default:          rd_val = mcr_reg[7] ? tcr_reg : efr_reg;
                endcase
            end

            assign rx_ready_n_next[ch] = !((rx_cnt >= rx_trig) || (rx_cnt != 0));
            // tx ready: enough room or empty
            assign tx_ready_n_next[ch] = !((depth_eff - tx_cnt >= {1'b0, tx_trig}) ||
                                            (tx_cnt == 0));
            assign rts_n_next[ch] = auto_rts ? rts_halt_reg
                                             : !mcr_reg[`UFC_MCR_RTS];
            assign serial_out_next[ch] = loop_on ? 1'b1 : ser_tx_line[ch];
            assign cts_change_next[ch] = cts_chg_reg;
            assign rd_mux[ch*8 +: 8] = rd_val;
        end
    endgenerate

    always @(posedge mclk) begin
        if (!rst_n) begin
            rd_data          <= 8'h00;
            serial_out_chan0 <= 1'b1;
            serial_out_chan1 <= 1'b1;
            rts_n_chan0      <= 1'b1;
            rts_n_chan1      <= 1'b1;
            rx_ready_n_chan0 <= 1'b1;
            rx_ready_n_chan1 <= 1'b1;
            tx_ready_n_chan0 <= 1'b0;
            tx_ready_n_chan1 <= 1'b0;
            cts_change_chan0 <= 1'b0;
            cts_change_chan1 <= 1'b0;
        end else begin
            rd_data          <= (rd_stb && sel[0]) ? rd_mux[7:0] :
                                (rd_stb && sel[1]) ? rd_mux[15:8] : 8'h00;
            serial_out_chan0 <= serial_out_next[0];
            serial_out_chan1 <= serial_out_next[1];
            rts_n_chan0      <= rts_n_next[0];
            rts_n_chan1      <= rts_n_next[1];
            rx_ready_n_chan0 <= rx_ready_n_next[0];
            rx_ready_n_chan1 <= rx_ready_n_next[1];
            tx_ready_n_chan0 <= tx_ready_n_next[0];
            tx_ready_n_chan1 <= tx_ready_n_next[1];
            cts_change_chan0 <= cts_change_next[0];
            cts_change_chan1 <= cts_change_next[1];
        end
    end
endmodule // ufc_top

// ### testbench/ufc_remote.sv
`timescale 1ns/1ns
// far-end uart, 8N1 at 16 clocks per bit (divisor 1)
module ufc_remote (
    input  wire mclk,
    input  wire line_in,
    output reg  line_out,
    output reg  cts_n
);
    logic [7:0] got_q[$];
    logic [7:0] sh;
    initial begin
        line_out = 1'b1;
        cts_n    = 1'b1;
    end
    // sample mid-bit: 8 to mid start, then 16 per bit
    always begin
        @(negedge line_in);
        repeat (24) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            sh[i] = line_in;
            repeat (16) @(posedge mclk);
        end
        got_q.push_back(sh);
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (16) @(posedge mclk);
        end
    endtask
    task automatic hold(input logic v);
        cts_n <= v;
    endtask
endmodule // ufc_remote

// ### testbench/ufc_chk.sv
`timescale 1ns/1ns
`include "ufc_defines.vh"
module ufc_chk (
    input wire       mclk,
    input wire       rst_n,
    input wire       cs_n,
    input wire       channel_addr_bit,
    input wire       wr_stb,
    input wire       rd_stb,
    input wire [2:0] addr,
    input wire [7:0] wr_data,
    input wire       cts_n_chan0,
    input wire       serial_out_chan0,
    input wire       rts_n_chan0,
    input wire       rts_n_chan1,
    input wire       rx_ready_n_chan0,
    input wire       tx_ready_n_chan0,
    input wire       cts_change_chan0
);
    logic [7:0] mcr_reg;
    logic [7:0] efr_reg;
    logic [1:0] quiet_reg;
    logic [4:0] age_reg;
    wire        wr0 = wr_stb && !cs_n && !channel_addr_bit;
    // quiet counts settled cycles since a selected write, hides output latency
    always @(posedge mclk) begin
        if (!rst_n) begin
            mcr_reg   <= 8'h00;
            efr_reg   <= 8'h00;
            quiet_reg <= 2'h0;
            age_reg   <= 5'h1F;
        end else begin
            if (wr0 && addr == `UFC_ADDR_MCR) mcr_reg <= wr_data;
            if (wr0 && addr == `UFC_ADDR_EFR_TCR && !mcr_reg[7]) efr_reg <= wr_data;
            quiet_reg <= (wr_stb && !cs_n) ? 2'h0 : quiet_reg + {1'b0, quiet_reg != 2'h3};
            age_reg   <= !cts_n_chan0 ? 5'h00 : age_reg + {4'h0, age_reg != 5'h1F};
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reset_state_a: assert property ($rose(rst_n) |-> serial_out_chan0 && rts_n_chan0
        && rx_ready_n_chan0 && !tx_ready_n_chan0 && !cts_change_chan0) else $error("reset state");
    rts_manual_a: assert property (quiet_reg == 2'h3 && !efr_reg[6] |->
        rts_n_chan0 == !mcr_reg[1]) else $error("rts not following modem control");
    loop_idle_a: assert property (quiet_reg == 2'h3 && mcr_reg[4] |-> serial_out_chan0)
        else $error("serial out active in loop-back");
    cts_quiet_a: assert property (quiet_reg == 2'h3 && efr_reg[7] |-> !cts_change_chan0)
        else $error("cts event with auto cts");
    cs_none_a: assert property (cs_n && wr_stb && quiet_reg == 2'h3 && !efr_reg[6] |=>
        ($stable(rts_n_chan0) && $stable(rts_n_chan1)) [*3]) else $error("unselected write took");
    rx_clear_a: assert property ($rose(rx_ready_n_chan0) |->
        $past(rd_stb) || $past(rd_stb, 2) || $past(rd_stb, 3)) else $error("rx ready rose unread");
    tx_busy_a: assert property ($rose(tx_ready_n_chan0) |->
        $past(wr_stb) || $past(wr_stb, 2) || $past(wr_stb, 3)) else $error("tx ready rose unwritten");
    cts_gate_a: assert property (efr_reg[7] && quiet_reg == 2'h3 && $fell(serial_out_chan0) |->
        age_reg < 5'h18) else $error("start while cts inactive");
    cover property ($fell(rx_ready_n_chan0));
    cover property (efr_reg[6] && $rose(rts_n_chan0));
    cover property (mcr_reg[4] && $fell(rx_ready_n_chan0));
endmodule // ufc_chk
bind ufc_top ufc_chk chk (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n),
    .channel_addr_bit(channel_addr_bit), .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr),
    .wr_data(wr_data), .cts_n_chan0(cts_n_chan0), .serial_out_chan0(serial_out_chan0),
    .rts_n_chan0(rts_n_chan0), .rts_n_chan1(rts_n_chan1), .rx_ready_n_chan0(rx_ready_n_chan0),
    .tx_ready_n_chan0(tx_ready_n_chan0), .cts_change_chan0(cts_change_chan0));

// ### testbench/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_top;
    logic       mclk = 0, rst_n = 0, cs_n = 1, chan = 0, wr_stb = 0, rd_stb = 0;
    logic [2:0] addr = 0;
    logic [7:0] wd   = 0, b, rdv;
    logic [7:0] exp_q[$];
    wire  [7:0] rd_data;
    wire        so0, so1, rts0, rts1, rxr0, rxr1, txr0, txr1, cc0, cc1, si0, cts0;
    int         fails = 0, compares = 0;
    ufc_top uut (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .channel_addr_bit(chan),
        .addr(addr), .wr_data(wd), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .serial_in_chan0(si0), .serial_in_chan1(1'b1), .cts_n_chan0(cts0), .cts_n_chan1(1'b1),
        .serial_out_chan0(so0), .serial_out_chan1(so1), .rts_n_chan0(rts0), .rts_n_chan1(rts1),
        .rx_ready_n_chan0(rxr0), .rx_ready_n_chan1(rxr1), .tx_ready_n_chan0(txr0),
        .tx_ready_n_chan1(txr1), .cts_change_chan0(cc0), .cts_change_chan1(cc1));
    ufc_remote rp (.mclk(mclk), .line_in(so0), .line_out(si0), .cts_n(cts0));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic print_verdict;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bus(input logic s, c, w, input logic [2:0] a, input logic [7:0] d);
        cs_n   <= s;
        chan   <= c;
        wr_stb <= w;
        rd_stb <= !w;
        addr   <= a;
        wd     <= d;
        @(posedge mclk);
        cs_n   <= 1'b1;
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        @(posedge mclk);
        rdv = rd_data; // read data stand only in this cycle
        repeat (2) @(posedge mclk);
    endtask
    task automatic w0(input logic [2:0] a, input logic [7:0] d);
        bus(1'b0, 1'b0, 1'b1, a, d);
    endtask
    // reads the data register; the byte lands in rdv
    task automatic r0;
        bus(1'b0, 1'b0, 1'b0, 3'h0, 8'h00);
    endtask
    // w 0: rx ready, 1: rts, 10+n: remote has n bytes
    function automatic logic sig(input int w);
        return w >= 10 ? rp.got_q.size() >= w - 10 : (w == 1 ? rts0 : rxr0);
    endfunction
    task automatic wt(input int w, input logic v);
        int n;
        n = 0;
        while (sig(w) !== v && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        if (n == 5000) begin
            fails++;
            $display("CHECK FAILED t=%0t wait ran out", $time);
            print_verdict;
        end
    endtask
    initial begin
        void'($urandom(77940));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1 `CHK({so0, rts0, rxr0, txr0, so1, rxr1, txr1, cc1}, 8'hEC, "reset")
        @(posedge mclk);
        w0(3'h5, 8'h02);
        `CHK(rts0, 1'b0, "rts manual set")
        w0(3'h5, 8'h00);
        `CHK(rts0, 1'b1, "rts manual clear")
        bus(1'b1, 1'b1, 1'b1, 3'h5, 8'h02);
        `CHK(rts1, 1'b1, "deselected write")
        bus(1'b0, 1'b1, 1'b1, 3'h5, 8'h02);
        `CHK({rts1, rts0}, 2'h1, "channel one select")
        bus(1'b0, 1'b1, 1'b1, 3'h5, 8'h00);
        $display("test 1 done");
        b = 8'($urandom);
        rp.send(b);
        wt(0, 1'b0);
        `CHK(rxr0, 1'b0, "rx ready one byte")
        r0;
        `CHK(rdv, b, "rx byte")
        wt(0, 1'b1);
        `CHK(rxr0, 1'b1, "rx ready empty")
        $display("test 2 done");
        w0(3'h1, 8'h01);
        w0(3'h2, 8'h00);
        w0(3'h3, 8'h01);
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            w0(3'h0, b);
        end
        wt(13, 1'b1);
        for (int i = 0; i < 3; i++) `CHK(rp.got_q.pop_front(), exp_q.pop_front(), "tx")
        for (int i = 0; i < 2; i++) begin
            rp.hold(i[0]);
            repeat (3) @(posedge mclk);
            `CHK(cc0, 1'b1, "cts change seen")
        end
        $display("test 3 done");
        w0(3'h7, 8'h80);
        w0(3'h3, 8'h00);
        for (int i = 0; i < 2; i++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            w0(3'h0, b);
            if (i == 0) `CHK(txr0, 1'b1, "tx ready full")
            if (i == 0) w0(3'h3, 8'h01);
        end
        repeat (300) @(posedge mclk);
        `CHK(rp.got_q.size(), 0, "sent while cts off")
        `CHK(txr0, 1'b0, "tx ready room")
        rp.hold(1'b0);
        repeat (100) @(posedge mclk);
        rp.hold(1'b1);
        repeat (400) @(posedge mclk);
        `CHK(rp.got_q.size(), 1, "next byte withheld")
        `CHK(rp.got_q.pop_front(), exp_q.pop_front(), "current byte")
        rp.hold(1'b0);
        wt(11, 1'b1);
        `CHK(rp.got_q.pop_front(), exp_q.pop_front(), "resumed byte")
        w0(3'h7, 8'h00);
        $display("test 4 done");
        w0(3'h5, 8'h80);
        w0(3'h7, 8'h01);
        w0(3'h5, 8'h00);
        w0(3'h7, 8'h40);
        `CHK(rts0, 1'b0, "auto rts open")
        for (int i = 0; i < 5; i++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            rp.send(b);
            repeat (4) @(posedge mclk);
            if (i == 2) `CHK(rts0, 1'b0, "below halt")
            if (i == 3) `CHK(rts0, 1'b1, "halt at four")
        end
        for (int i = 0; i < 5; i++) begin
            r0;
            `CHK(rdv, exp_q.pop_front(), "rx fifo byte")
            if (i == 3) `CHK(rts0, 1'b1, "extra byte kept")
        end
        wt(1, 1'b0);
        `CHK(rts0, 1'b0, "resume at zero")
        w0(3'h7, 8'h00);
        $display("test 5 done");
        w0(3'h5, 8'h10);
        b = 8'($urandom);
        w0(3'h0, b);
        wt(0, 1'b0);
        `CHK(rp.got_q.size(), 0, "loop-back leaked")
        r0;
        `CHK(rdv, b, "looped byte")
        w0(3'h5, 8'h00);
        `CHK({so1, rxr1, txr1, cc1}, 4'hC, "channel one idle")
        $display("test 6 done");
        print_verdict;
    end
endmodule // tb_top
